// [bcd_defs.svh]
// constants of the bridge control command decoder
// assumes a 40 MHz aclk and an AXI4-Lite register window
// Contract
// - accepted command and parameter bytes are acknowledged, bad ones are not
// - each command repositions the read pointer to its relevant register
// - pointer codes: status F0h, read data E1h, configuration C3h only
// - code F0h resets the decoder state and aborts any line transfer
// - line activity stops within 262.5ns of the reset ack falling edge
// - the reset command completes within 525ns of that falling edge
// - reset is accepted at any time, even while busy, never refused
// - reset sets the reset flag and clears busy and all result flags
// - reset clears speed, active pullup and strong pullup settings
// - after reset the read pointer selects the status register
// - code E1h plus a selection code moves the pointer, at any time
// - pointer command overrides a pointer set by a running line command
// - invalid selection code is not acknowledged and pointer stays
// - new pointer takes effect on the rising edge of its ack clock
// - code D2h stores its byte only if upper nibble inverts lower
// - configuration reads return zero in the upper four bits
// - while busy, D2h code and its parameter are refused and dropped
// - valid configuration updates on its ack rising edge, no line activity
// - configuration write points at configuration and clears reset flag
// - busy reads one while the line engine runs, zero when done
// - configuration: speed bit 3, strong pullup bit 2, active pullup bit 0
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

// serial bus address and command codes
`define BCD_I2C_ADDR     7'h18
`define BCD_CMD_RESET    8'hF0
`define BCD_CMD_POINTER  8'hE1
`define BCD_CMD_CONFIG   8'hD2
`define BCD_SEL_STATUS   8'hF0
`define BCD_SEL_RDATA    8'hE1
`define BCD_SEL_CONFIG   8'hC3

// configuration and status field positions
`define BCD_CFG_SPEED    3
`define BCD_CFG_SPU      2
`define BCD_CFG_APU      0
`define BCD_ST_BUSY      0
`define BCD_ST_RST       4

// register byte offsets
`define BCD_REG_STATUS   8'h00
`define BCD_REG_CONFIG   8'h04
`define BCD_REG_POINTER  8'h08
`define BCD_REG_RDATA    8'h0C

// timing, in ns as printed, and the clock period
`define BCD_CLK_NS       25.0
`define BCD_ABORT_NS     262.5
`define BCD_DONE_NS      525.0

`endif

// [bcd_pkg.sv]
// types of the command decoder; its serial front end does not use them
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package bcd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR  = 2'b01,
    ST_CFG  = 2'b10,
    ST_DONE = 2'b11
  } bcd_state_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_RST  = 2'b01,
    ACT_PTR  = 2'b10,
    ACT_CFG  = 2'b11
  } bcd_act_t;

  typedef enum logic [1:0] {
    PTR_STAT = 2'b00,
    PTR_DATA = 2'b01,
    PTR_CFG  = 2'b10
  } bcd_ptr_t;
endpackage
`default_nettype wire

// [bcd_link_if.sv]
// byte link between the serial front end and the command decoder
// assumes both ends run on aclk
`default_nettype none
interface bcd_link_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       ack_ok;
  logic       ack_rise;
  logic       ack_fall;
  logic       bus_edge;
  modport rx  (output byte_valid, byte_data, ack_rise, ack_fall, bus_edge,
               input ack_ok);
  modport dec (input byte_valid, byte_data, ack_rise, ack_fall, bus_edge,
               output ack_ok);
endinterface
`default_nettype wire

// [bcd_i2c_rx.sv]
// serial bus write-side front end: sync, start/stop, byte shift, ack drive
// assumes scl and sda arrive asynchronously and SCL is much slower than aclk
`default_nettype none
`include "bcd_defs.svh"
module bcd_i2c_rx #(
  parameter logic [6:0] ADDR = `BCD_I2C_ADDR
) (
  // clock and control
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe,
  // decoder side
  bcd_link_if.rx    lk
);
  logic       scl_s1, scl_s2, scl_d;
  logic       sda_s1, sda_s2, sda_d;
  logic       active, addr_ph, in_ack, ack_q;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic       scl_rise, scl_fall, start_c, stop_c;

  // two flops per pin before any logic looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else if (ce) begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;

  // byte framing; a nacked byte drops us until the next start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active        <= 1'b0;
      addr_ph       <= 1'b1;
      in_ack        <= 1'b0;
      ack_q         <= 1'b0;
      bitcnt        <= 4'h0;
      shreg         <= 8'h00;
      sda_oe        <= 1'b0;
      lk.byte_valid <= 1'b0;
      lk.byte_data  <= 8'h00;
      lk.ack_rise   <= 1'b0;
      lk.ack_fall   <= 1'b0;
      lk.bus_edge   <= 1'b0;
    end else if (ce) begin
      lk.byte_valid <= 1'b0;
      lk.ack_rise   <= 1'b0;
      lk.ack_fall   <= 1'b0;
      lk.bus_edge   <= 1'b0;
      if (lk.byte_valid) begin
        ack_q <= lk.ack_ok; // decoder answers in the byte_valid cycle
      end
      if (start_c || stop_c) begin
        active      <= start_c;
        addr_ph     <= 1'b1;
        bitcnt      <= 4'h0;
        in_ack      <= 1'b0;
        sda_oe      <= 1'b0;
        lk.bus_edge <= 1'b1;
      end else if (active) begin
        if (scl_rise && bitcnt < 4'h8) begin
          shreg  <= {shreg[6:0], sda_s2};
          bitcnt <= bitcnt + 4'h1;
          if (bitcnt == 4'h7) begin
            if (addr_ph) begin
              ack_q <= ({shreg[6:0], sda_s2} == {ADDR, 1'b0});
            end else begin
              lk.byte_valid <= 1'b1;
              lk.byte_data  <= {shreg[6:0], sda_s2};
            end
          end
        end else if (scl_rise && in_ack) begin
          lk.ack_rise <= ack_q & ~addr_ph;
        end else if (scl_fall && bitcnt == 4'h8 && !in_ack) begin
          sda_oe <= ack_q;
          in_ack <= 1'b1;
        end else if (scl_fall && in_ack) begin
          sda_oe      <= 1'b0;
          in_ack      <= 1'b0;
          bitcnt      <= 4'h0;
          addr_ph     <= 1'b0;
          lk.ack_fall <= ack_q & ~addr_ph;
          if (!ack_q) begin
            active <= 1'b0;
          end
        end
      end
    end
  end
endmodule // bcd_i2c_rx
`default_nettype wire

// [bcd_top.sv]
// control-class command decoder of a serial-bus to single-wire bridge
// assumes a line engine on aclk beside it and an AXI4-Lite master
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
`include "bcd_defs.svh"
module bcd_top #(
  parameter int         ADDR_W   = 8,
  parameter logic [6:0] I2C_ADDR = `BCD_I2C_ADDR
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // serial host bus pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // line engine side
  input  wire logic              ow_busy,
  input  wire logic              ow_result_we,
  input  wire logic [4:0]        ow_result,
  input  wire logic              ow_ptr_status,
  input  wire logic              ow_spu_end,
  input  wire logic [7:0]        ow_rdata,
  output logic                   ow_abort,
  output logic                   speed_select,
  output logic                   strong_pullup_enable,
  output logic                   active_pullup_enable,
  output logic [7:0]             read_sel_code
);
  localparam int ABORT_CYC = int'($floor(`BCD_ABORT_NS / `BCD_CLK_NS));
  localparam int DONE_CYC  = int'($floor(`BCD_DONE_NS / `BCD_CLK_NS));

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("bcd_top: ADDR_W must lie in 8..32");
  end

  bcd_link_if lk ();

  bcd_pkg::bcd_state_t st_r, st_nxt;
  bcd_pkg::bcd_act_t   pend_r, pend_nxt;
  bcd_pkg::bcd_ptr_t   rptr_r;
  logic [7:0]          par_r;
  logic                busy_r, rst_flag_r;
  logic                ppd_r, sd_r, sbr_r, tsb_r, dir_r;
  logic                ack_ok, do_rst, do_ptr, do_cfg;
  logic                ptr_ok, cfg_ok;
  logic [7:0]          status_byte, cfg_byte;
  logic                wr_go, rd_go;
  logic [31:0]         rd_word;
  logic [1:0]          rd_resp;

  bcd_i2c_rx #(
    .ADDR    (I2C_ADDR)
  ) u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_oe  (sda_oe),
    .lk      (lk.rx)
  );

  // open-drain: only ever pulls low
  assign sda_o = 1'b0;

  // selection code to pointer; anything else maps to the status pointer
  function automatic bcd_pkg::bcd_ptr_t sel_to_ptr(input logic [7:0] c);
    if (c == `BCD_SEL_RDATA) begin
      return bcd_pkg::PTR_DATA;
    end else if (c == `BCD_SEL_CONFIG) begin
      return bcd_pkg::PTR_CFG;
    end
    return bcd_pkg::PTR_STAT;
  endfunction

  assign ptr_ok = (lk.byte_data == `BCD_SEL_STATUS) ||
                  (lk.byte_data == `BCD_SEL_RDATA)  ||
                  (lk.byte_data == `BCD_SEL_CONFIG);
  assign cfg_ok = (lk.byte_data[7:4] == ~lk.byte_data[3:0]);

  // decoder: decide ack while the byte is fresh, remember what to do
  always_comb begin
    ack_ok   = 1'b0;
    st_nxt   = st_r;
    pend_nxt = pend_r;
    if (lk.byte_valid) begin
      case (st_r)
        bcd_pkg::ST_IDLE: begin
          st_nxt = bcd_pkg::ST_DONE;
          if (lk.byte_data == `BCD_CMD_RESET) begin
            ack_ok   = 1'b1;
            pend_nxt = bcd_pkg::ACT_RST;
          end else if (lk.byte_data == `BCD_CMD_POINTER) begin
            ack_ok = 1'b1;
            st_nxt = bcd_pkg::ST_PTR;
          end else if (lk.byte_data == `BCD_CMD_CONFIG && !busy_r) begin
            ack_ok = 1'b1;
            st_nxt = bcd_pkg::ST_CFG;
          end
        end
        bcd_pkg::ST_PTR: begin
          st_nxt = bcd_pkg::ST_DONE;
          if (ptr_ok) begin
            ack_ok   = 1'b1;
            pend_nxt = bcd_pkg::ACT_PTR;
          end
        end
        bcd_pkg::ST_CFG: begin
          st_nxt = bcd_pkg::ST_DONE;
          if (cfg_ok) begin
            ack_ok   = 1'b1;
            pend_nxt = bcd_pkg::ACT_CFG;
          end
        end
        default: begin
          st_nxt = bcd_pkg::ST_DONE; // extra bytes
        end
      endcase
    end
    if (lk.ack_fall) begin
      pend_nxt = bcd_pkg::ACT_NONE;
    end
    if (lk.bus_edge) begin
      st_nxt   = bcd_pkg::ST_IDLE;
      pend_nxt = bcd_pkg::ACT_NONE;
    end
  end

  assign lk.ack_ok = ack_ok;

  // decoder state and captured parameter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= bcd_pkg::ST_IDLE;
      pend_r <= bcd_pkg::ACT_NONE;
      par_r  <= 8'h00;
    end else if (ce) begin
      st_r   <= st_nxt;
      pend_r <= pend_nxt;
      if (lk.byte_valid && st_r != bcd_pkg::ST_IDLE) begin
        par_r <= lk.byte_data;
      end
    end
  end

  // reset acts at the ack falling edge, pointer and config at its rise
  assign do_rst = lk.ack_fall && pend_r == bcd_pkg::ACT_RST;
  assign do_ptr = lk.ack_rise && pend_r == bcd_pkg::ACT_PTR;
  assign do_cfg = lk.ack_rise && pend_r == bcd_pkg::ACT_CFG;

  // abort pulse to the line engine, one cycle after the falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ow_abort <= 1'b0;
    end else if (ce) begin
      ow_abort <= do_rst;
    end
  end

  // busy mirrors the engine but is dropped at once by a reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= ow_busy & ~do_rst;
    end
  end

  // result flags from the engine; reset clears them all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {dir_r, tsb_r, sbr_r, sd_r, ppd_r} <= 5'h00;
    end else if (ce) begin
      if (do_rst) begin
        {dir_r, tsb_r, sbr_r, sd_r, ppd_r} <= 5'h00;
      end else if (ow_result_we) begin
        {dir_r, tsb_r, sbr_r, sd_r, ppd_r} <= ow_result;
      end
    end
  end

  // reset-occurred flag: power-up and reset command set it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_flag_r <= 1'b1;
    end else if (ce) begin
      if (do_rst) begin
        rst_flag_r <= 1'b1;
      end else if (do_cfg) begin
        rst_flag_r <= 1'b0;
      end
    end
  end

  // read pointer; a host pointer command beats the engine's request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rptr_r <= bcd_pkg::PTR_STAT;
    end else if (ce) begin
      if (do_rst) begin
        rptr_r <= bcd_pkg::PTR_STAT;
      end else if (do_ptr) begin
        rptr_r <= sel_to_ptr(par_r);
      end else if (do_cfg) begin
        rptr_r <= bcd_pkg::PTR_CFG;
      end else if (ow_ptr_status) begin
        rptr_r <= bcd_pkg::PTR_STAT;
      end
    end
  end

  assign wr_go   = awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready  = wr_go;

  // configuration bits; a write beats the strong pullup ending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_select         <= 1'b0;
      strong_pullup_enable <= 1'b0;
      active_pullup_enable <= 1'b0;
    end else if (ce) begin
      if (do_rst) begin
        speed_select         <= 1'b0;
        strong_pullup_enable <= 1'b0;
        active_pullup_enable <= 1'b0;
      end else if (do_cfg) begin
        speed_select         <= par_r[`BCD_CFG_SPEED];
        strong_pullup_enable <= par_r[`BCD_CFG_SPU];
        active_pullup_enable <= par_r[`BCD_CFG_APU];
      end else if (wr_go && wstrb[0] &&
                   awaddr[7:0] == `BCD_REG_CONFIG) begin
        speed_select         <= wdata[`BCD_CFG_SPEED];
        strong_pullup_enable <= wdata[`BCD_CFG_SPU];
        active_pullup_enable <= wdata[`BCD_CFG_APU];
      end else if (ow_spu_end) begin
        strong_pullup_enable <= 1'b0;
      end
    end
  end

  assign status_byte = {dir_r, tsb_r, sbr_r, rst_flag_r, 1'b0,
                        sd_r, ppd_r, busy_r};
  // upper nibble is never stored, so it always reads zero
  assign cfg_byte = {4'h0, speed_select, strong_pullup_enable, 1'b0,
                     active_pullup_enable};

  // pointer code shown to the engine and to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_sel_code <= `BCD_SEL_STATUS;
    end else if (ce) begin
      case (rptr_r)
        bcd_pkg::PTR_DATA: read_sel_code <= `BCD_SEL_RDATA;
        bcd_pkg::PTR_CFG:  read_sel_code <= `BCD_SEL_CONFIG;
        default:           read_sel_code <= `BCD_SEL_STATUS;
      endcase
    end
  end

  // write response: read-only registers ignore data, holes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        if (awaddr[7:0] == `BCD_REG_STATUS ||
            awaddr[7:0] == `BCD_REG_CONFIG ||
            awaddr[7:0] == `BCD_REG_POINTER ||
            awaddr[7:0] == `BCD_REG_RDATA) begin
          bresp <= 2'h0;
        end else begin
          bresp <= 2'h2;
        end
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign rd_go   = arvalid & ~rvalid;
  assign arready = rd_go;

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = 2'h0;
    if (araddr[7:0] == `BCD_REG_STATUS) begin
      rd_word = {24'h00_0000, status_byte};
    end else if (araddr[7:0] == `BCD_REG_CONFIG) begin
      rd_word = {24'h00_0000, cfg_byte};
    end else if (araddr[7:0] == `BCD_REG_POINTER) begin
      rd_word = {24'h00_0000, read_sel_code};
    end else if (araddr[7:0] == `BCD_REG_RDATA) begin
      rd_word = {24'h00_0000, ow_rdata};
    end else begin
      rd_resp = 2'h2;
    end
  end

  // read data held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else if (ce) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_resp;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // checks, frozen with the clock enable
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_rst_ack;
    lk.ack_fall && pend_r == bcd_pkg::ACT_RST;
  endsequence

  sequence s_rst_done;
    rptr_r == bcd_pkg::PTR_STAT && rst_flag_r && !busy_r &&
    !speed_select && !strong_pullup_enable && !active_pullup_enable;
  endsequence

  AST_ABORT_TIME: assert property (
    s_rst_ack |-> ##[1:ABORT_CYC] ow_abort)
    else $error("abort not raised in time after reset command");

  AST_RESET_DONE: assert property (
    s_rst_ack |-> ##[1:DONE_CYC] s_rst_done)
    else $error("reset command did not complete in time");

  AST_RESET_ACK: assert property (
    lk.byte_valid && st_r == bcd_pkg::ST_IDLE &&
    lk.byte_data == `BCD_CMD_RESET |-> ack_ok)
    else $error("reset code not acknowledged");

  AST_PTR_BAD: assert property (
    lk.byte_valid && st_r == bcd_pkg::ST_PTR && !ptr_ok
    |-> !ack_ok ##1 pend_r == bcd_pkg::ACT_NONE)
    else $error("invalid pointer code accepted");

  AST_PTR_APPLY: assert property (
    do_ptr |=> rptr_r == sel_to_ptr($past(par_r)))
    else $error("pointer not updated at ack rise");

  AST_CFG_BUSY: assert property (
    lk.byte_valid && st_r == bcd_pkg::ST_IDLE && busy_r &&
    lk.byte_data == `BCD_CMD_CONFIG |-> !ack_ok ##1 st_r == bcd_pkg::ST_DONE)
    else $error("config code accepted while busy");

  AST_CFG_APPLY: assert property (
    do_cfg |=> rptr_r == bcd_pkg::PTR_CFG && !rst_flag_r &&
    speed_select == $past(par_r[`BCD_CFG_SPEED]))
    else $error("config write effects missing");

  AST_CFG_UPPER: assert property (
    rd_go && araddr[7:0] == `BCD_REG_CONFIG |=> rdata[7:4] == 4'h0)
    else $error("config upper nibble not zero");

  AST_EXTRA_NACK: assert property (
    lk.byte_valid && st_r == bcd_pkg::ST_DONE |-> !ack_ok)
    else $error("byte beyond command length acknowledged");
endmodule // bcd_top
`default_nettype wire

// [bcd_i2c_host.sv]
// serial bus host model: start, byte writes, ack sampling, stop
// assumes the bench resolves sda as open drain with a pull-up
`default_nettype none
module bcd_i2c_host (
  // clock
  input  wire logic aclk,
  // bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles released and high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // a half of the 200 ns bus clock is four aclk cycles
  task automatic q(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // msb first; sda moves one cycle into the low phase, never with scl
  task automatic put(input logic [7:0] b, output logic k);
    for (int i = 7; i >= 0; i--) begin
      q(1);
      sda_low <= ~b[i];
      q(3);
      scl <= 1'b1;
      q(4);
      scl <= 1'b0;
    end
    q(1);
    sda_low <= 1'b0;  // release for the ack slot
    q(3);
    scl <= 1'b1;
    q(2);
    k = ~sda_line;
    q(2);
    scl <= 1'b0;
  endtask

  // start, address, up to n bytes while acked, stop
  task automatic tr(input logic [7:0] a, c, p, input int n,
                    output logic [3:0] k);
    k = 4'h0;
    q(1);
    sda_low <= 1'b1;
    q(4);
    scl <= 1'b0;
    put(a, k[3]);
    for (int i = 0; i < n && k[3-i]; i++)
      put(i == 0 ? c : p, k[2-i]);
    q(1);
    sda_low <= 1'b1;
    q(3);
    scl <= 1'b1;
    q(4);
    sda_low <= 1'b0;
    q(4);
  endtask
endmodule // bcd_i2c_host
`default_nettype wire

// [bcd_top_tb.sv]
// self-checking bench of the control command decoder
// assumes the serial host model and a 40 MHz aclk
`default_nettype none
`include "bcd_defs.svh"
module bcd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A = {`BCD_I2C_ADDR, 1'b0};
  logic aclk = 1'b0, aresetn = 1'b0, scl, sda_low, sda_line, scl_q = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ow_rdata = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ow_busy = 1'b0;
  logic ow_result_we = 1'b0, ow_ptr_status = 1'b0;
  logic busy_req = 1'b0, ow_spu_end = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [4:0] ow_result = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, ow_abort;
  logic speed_select, strong_pullup_enable, active_pullup_enable;
  logic [1:0] bresp, rresp;
  logic [7:0] read_sel_code;
  logic [3:0] k;
  logic [7:0] codes [3] = '{8'hE1, 8'hC3, 8'hF0};
  int mismatches = 0, n_tests = 0, sc = 0, ab = 99;

  // open drain with pull-up: low if either party pulls
  assign sda_line = ~(sda_low | sda_oe);

  // clock
  initial forever #12.5 aclk = ~aclk;

  bcd_top dut (.aclk, .aresetn, .ce(1'b1), .scl_i(scl), .sda_i(sda_line),
    .sda_o, .sda_oe, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ow_busy, .ow_result_we,
    .ow_result, .ow_ptr_status, .ow_spu_end, .ow_rdata, .ow_abort,
    .speed_select, .strong_pullup_enable, .active_pullup_enable,
    .read_sel_code);

  bcd_i2c_host host (.aclk, .scl, .sda_low, .sda_line);

  // cycles since the last scl fall, latched at the abort pulse
  always @(posedge aclk) begin
    scl_q <= scl;
    sc <= (scl_q && !scl) ? 0 : sc + 1;
    if (ow_abort === 1'b1) ab <= sc;
    if (ow_abort === 1'b1) ow_busy <= 1'b0;  // engine obeys the abort
    else if (busy_req) ow_busy <= 1'b1;
  end

  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic ad, wd, bd;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at its own handshake edge
    while (!bd) begin
      @(posedge aclk);
      bd = ad && wd && bvalid === 1'b1;
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // whole run is some 2600 cycles; a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    results();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`BCD_REG_STATUS, 32'h10, 2'h0);
    chk(32'(read_sel_code), 32'(`BCD_SEL_STATUS));
    host.tr(A, `BCD_CMD_CONFIG, 8'h11, 2, k);
    chk(32'(k), 32'hC);
    chk(32'(sda_o), 32'h0);
    rd(`BCD_REG_CONFIG, 32'h0, 2'h0);
    host.tr(A, `BCD_CMD_CONFIG, 8'h2D, 2, k);
    chk(32'(k), 32'hE);
    chk(32'({speed_select, strong_pullup_enable, active_pullup_enable}),
        32'h7);
    rd(`BCD_REG_CONFIG, 32'h0D, 2'h0);
    rd(`BCD_REG_STATUS, 32'h00, 2'h0);
    chk(32'(read_sel_code), 32'(`BCD_SEL_CONFIG));
    foreach (codes[i]) begin
      host.tr(A, `BCD_CMD_POINTER, codes[i], 2, k);
      chk(32'(k), 32'hE);
      chk(32'(read_sel_code), 32'(codes[i]));
      rd(`BCD_REG_POINTER, 32'(codes[i]), 2'h0);
    end
    host.tr(A, `BCD_CMD_POINTER, 8'h55, 2, k);
    chk(32'(k), 32'hC);
    chk(32'(read_sel_code), 32'hF0);
    host.tr(A, `BCD_CMD_POINTER, 8'hC3, 3, k);
    chk(32'(k), 32'hE);
    host.tr(A | 8'h02, `BCD_CMD_POINTER, 8'hF0, 2, k);
    chk(32'(k), 32'h0);
    host.tr(A, 8'h5A, 8'h00, 1, k);
    chk(32'(k), 32'h8);
    chk(32'(read_sel_code), 32'hC3);
    // line engine busy with a result and its own pointer request
    ow_rdata <= 8'h5A;
    busy_req <= 1'b1;
    ow_result <= 5'h15;
    ow_result_we <= 1'b1;
    ow_ptr_status <= 1'b1;
    @(posedge aclk);
    busy_req <= 1'b0;
    ow_result_we <= 1'b0;
    ow_ptr_status <= 1'b0;
    rd(`BCD_REG_STATUS, 32'hA3, 2'h0);
    host.tr(A, `BCD_CMD_POINTER, `BCD_SEL_RDATA, 2, k);
    chk(32'(k), 32'hE);
    rd(`BCD_REG_RDATA, 32'h5A, 2'h0);
    host.tr(A, `BCD_CMD_CONFIG, 8'h87, 2, k);
    chk(32'(k), 32'h8);
    rd(`BCD_REG_CONFIG, 32'h0D, 2'h0);
    host.tr(A, `BCD_CMD_RESET, 8'h00, 1, k);
    chk(32'(k), 32'hC);
    chk(32'(ab <= 10), 32'h1);
    rd(`BCD_REG_STATUS, 32'h10, 2'h0);
    rd(`BCD_REG_CONFIG, 32'h00, 2'h0);
    chk(32'({speed_select, strong_pullup_enable, active_pullup_enable}),
        32'h0);
    chk(32'(read_sel_code), 32'hF0);
    wr(`BCD_REG_CONFIG, 32'h4, 2'h0);
    rd(`BCD_REG_CONFIG, 32'h4, 2'h0);
    // end of strong pullup drops its enable bit only
    ow_spu_end <= 1'b1;
    @(posedge aclk);
    ow_spu_end <= 1'b0;
    rd(`BCD_REG_CONFIG, 32'h0, 2'h0);
    wr(8'h20, 32'h0, 2'h2);
    rd(8'h10, 32'h0, 2'h2);
    results();
  end
endmodule // bcd_top_tb
`default_nettype wire
